// >>> iql_pkg.sv
// package for the interrupt queue length register bank
// assumes a plain single-cycle register port and one clock domain
// Functional notes
// - channel length register, RW, reset zero; rx codes high half, channel 0 top nibble
// - receive queue length is (1 + rx code) times 32 doublewords, codes 0 to 15
// - config queue length is (1 + code) times 32; code at shared bits 23:20
// - peripheral queue length is (1 + code) times 32; code at shared bits 19:16
// - shared length register, RW, reset zero; bits 31:24 and 15:0 read zero
package iql_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned CODE_W        = 4;
   localparam int unsigned LEN_W         = 10;
   localparam int unsigned NUM_CH        = 4;
   localparam int unsigned UNIT_SHIFT    = 5;
   localparam logic [ADDR_W-1:0] CHAN_LEN_OFS   = 8'h0C;
   localparam logic [ADDR_W-1:0] SHARED_LEN_OFS = 8'h10;
   localparam logic [DATA_W-1:0] CHAN_LEN_RST   = 32'h00000000;
   localparam logic [DATA_W-1:0] SHARED_LEN_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] SHARED_LEN_MASK = 32'h00FF0000;
   localparam int unsigned RX_LSB0       = 28;
   localparam int unsigned TX_LSB0       = 12;
   localparam int unsigned CFG_LSB       = 20;
   localparam int unsigned PER_LSB       = 16;
   localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h00000000;
endpackage : iql_pkg

// >>> iql_len_calc.sv
// converts one 4-bit queue length code into a length in doublewords
// assumes the code comes from a register, so the result is registered too
`timescale 1ns/1ns
module iql_len_calc (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            arst_n,
   input  wire logic                            clk_en,
   // code in, length out
   input  wire logic [iql_pkg::CODE_W-1:0]      code,
   output logic      [iql_pkg::LEN_W-1:0]       len_dw
);
   logic [iql_pkg::LEN_W-1:0] len_ff;
   logic [iql_pkg::LEN_W-1:0] nxt_len;

   always_comb begin
      // (code + 1) * 32, widened first so code 15 gives 512 without wrap
      nxt_len = iql_pkg::LEN_W'({1'b0, code} + 5'h01) << iql_pkg::UNIT_SHIFT;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         len_ff <= iql_pkg::LEN_W'(32);
      end else if (clk_en) begin
         len_ff <= nxt_len;
      end
   end

   assign len_dw = len_ff;
endmodule : iql_len_calc

// >>> iql_regs.sv
// interrupt queue length register bank with decoded queue lengths
// assumes one-cycle strobes from the master and read data taken the next cycle
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
module iql_regs (
   // clock and reset
   input  wire logic                             clk,
   input  wire logic                             arst_n,
   input  wire logic                             clk_en,
   // register port
   input  wire logic [iql_pkg::ADDR_W-1:0]       reg_addr,
   input  wire logic [iql_pkg::DATA_W-1:0]       reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [iql_pkg::DATA_W-1:0]       reg_rdata,
   // codes toward the dma logic
   output logic      [iql_pkg::CODE_W-1:0]       rx_queue_length_code [iql_pkg::NUM_CH],
   output logic      [iql_pkg::CODE_W-1:0]       tx_queue_length_code [iql_pkg::NUM_CH],
   output logic      [iql_pkg::CODE_W-1:0]       config_queue_length_code,
   output logic      [iql_pkg::CODE_W-1:0]       peripheral_queue_length_code,
   // queue lengths in doublewords, one cycle behind the codes
   output logic      [iql_pkg::LEN_W-1:0]        rx_queue_len_dw [iql_pkg::NUM_CH],
   output logic      [iql_pkg::LEN_W-1:0]        tx_queue_len_dw [iql_pkg::NUM_CH],
   output logic      [iql_pkg::LEN_W-1:0]        config_queue_len_dw,
   output logic      [iql_pkg::LEN_W-1:0]        peripheral_queue_len_dw
);
   logic [iql_pkg::DATA_W-1:0] chan_len_ff;
   logic [iql_pkg::DATA_W-1:0] shared_len_ff;
   logic [iql_pkg::DATA_W-1:0] rdata_ff;
   logic [iql_pkg::DATA_W-1:0] nxt_chan_len;
   logic [iql_pkg::DATA_W-1:0] nxt_shared_len;
   logic [iql_pkg::DATA_W-1:0] nxt_rdata;

   function automatic logic [iql_pkg::CODE_W-1:0] nib(
      input logic [iql_pkg::DATA_W-1:0] word,
      input int unsigned                lsb);
      nib = word[lsb +: iql_pkg::CODE_W];
   endfunction : nib

   always_comb begin
      nxt_chan_len   = chan_len_ff;
      nxt_shared_len = shared_len_ff;
      nxt_rdata      = rdata_ff;
      if (reg_wr && reg_addr == iql_pkg::CHAN_LEN_OFS) begin
         nxt_chan_len = reg_wdata;
      end
      if (reg_wr && reg_addr == iql_pkg::SHARED_LEN_OFS) begin
         // unused bits are never stored, so they always read zero
         nxt_shared_len = reg_wdata & iql_pkg::SHARED_LEN_MASK;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            iql_pkg::CHAN_LEN_OFS:   nxt_rdata = chan_len_ff;
            iql_pkg::SHARED_LEN_OFS: nxt_rdata = shared_len_ff;
            default:                 nxt_rdata = iql_pkg::UNMAPPED_RD;
         endcase
      end else begin
         // data stands only in the cycle after the read strobe
         nxt_rdata = iql_pkg::UNMAPPED_RD;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chan_len_ff   <= iql_pkg::CHAN_LEN_RST;
         shared_len_ff <= iql_pkg::SHARED_LEN_RST;
         rdata_ff      <= iql_pkg::UNMAPPED_RD;
      end else if (clk_en) begin
         chan_len_ff   <= nxt_chan_len;
         shared_len_ff <= nxt_shared_len;
         rdata_ff      <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // channel 0 sits in the top nibble of each half
   for (genvar i = 0; i < iql_pkg::NUM_CH; i++) begin : g_ch
      assign rx_queue_length_code[i] = nib(chan_len_ff, iql_pkg::RX_LSB0 - 4 * i);
      assign tx_queue_length_code[i] = nib(chan_len_ff, iql_pkg::TX_LSB0 - 4 * i);

      iql_len_calc u_rx_len (
         .clk    (clk),
         .arst_n (arst_n),
         .clk_en (clk_en),
         .code   (rx_queue_length_code[i]),
         .len_dw (rx_queue_len_dw[i])
      );

      iql_len_calc u_tx_len (
         .clk    (clk),
         .arst_n (arst_n),
         .clk_en (clk_en),
         .code   (tx_queue_length_code[i]),
         .len_dw (tx_queue_len_dw[i])
      );
   end

   assign config_queue_length_code     = nib(shared_len_ff, iql_pkg::CFG_LSB);
   assign peripheral_queue_length_code = nib(shared_len_ff, iql_pkg::PER_LSB);

   iql_len_calc u_cfg_len (
      .clk    (clk),
      .arst_n (arst_n),
      .clk_en (clk_en),
      .code   (config_queue_length_code),
      .len_dw (config_queue_len_dw)
   );

   iql_len_calc u_per_len (
      .clk    (clk),
      .arst_n (arst_n),
      .clk_en (clk_en),
      .code   (peripheral_queue_length_code),
      .len_dw (peripheral_queue_len_dw)
   );

   // base alignment is software's job; lengths here count upward from the base
endmodule : iql_regs

// >>> iql_regs_checker.sv
// assertions for the queue length register bank
// assumes a bind onto iql_regs and a single clock domain
`timescale 1ns/1ns
module iql_regs_checker (
   // clock, reset and register port
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        clk_en,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // codes and lengths
   input wire logic [3:0]  rx_queue_length_code [4],
   input wire logic [3:0]  tx_queue_length_code [4],
   input wire logic [3:0]  config_queue_length_code,
   input wire logic [3:0]  peripheral_queue_length_code,
   input wire logic [9:0]  rx_queue_len_dw [4],
   input wire logic [9:0]  tx_queue_len_dw [4],
   input wire logic [9:0]  config_queue_len_dw,
   input wire logic [9:0]  peripheral_queue_len_dw
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // five-bit sum keeps code 15 from wrapping to zero
   function automatic logic [9:0] dw(input logic [3:0] c);
      return {c + 5'h01, 5'h00};
   endfunction : dw
   chk_chan_write: assert property (clk_en && reg_wr && reg_addr == iql_pkg::CHAN_LEN_OFS |=>
      {rx_queue_length_code[0], rx_queue_length_code[1], rx_queue_length_code[2],
       rx_queue_length_code[3], tx_queue_length_code[0], tx_queue_length_code[1],
       tx_queue_length_code[2], tx_queue_length_code[3]} == $past(reg_wdata))
      else $error("channel codes differ from written word");
   chk_shared_write: assert property (clk_en && reg_wr && reg_addr == iql_pkg::SHARED_LEN_OFS |=>
      {config_queue_length_code, peripheral_queue_length_code} == $past(reg_wdata[23:16]))
      else $error("shared codes differ from written word");
   chk_shared_read: assert property (clk_en && reg_rd && reg_addr == iql_pkg::SHARED_LEN_OFS |=>
      reg_rdata == {8'h00, config_queue_length_code, peripheral_queue_length_code, 16'h0000})
      else $error("shared read word wrong");
   chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside read cycle");
   chk_rx_len: assert property (clk_en |=> rx_queue_len_dw[1] == dw($past(rx_queue_length_code[1])))
      else $error("rx length wrong");
   chk_tx_len: assert property (clk_en |=> tx_queue_len_dw[2] == dw($past(tx_queue_length_code[2])))
      else $error("tx length wrong");
   chk_cfg_len: assert property (clk_en |=> config_queue_len_dw == dw($past(config_queue_length_code)))
      else $error("config length wrong");
   chk_per_len: assert property (clk_en |=>
      peripheral_queue_len_dw == dw($past(peripheral_queue_length_code)))
      else $error("peripheral length wrong");
endmodule : iql_regs_checker

// >>> iql_regs_test.sv
// self-checking bench for the queue length register bank
// holds clk_en high except while t_freeze drives it low; checker bound below
`timescale 1ns/1ns
module iql_regs_test;
   logic        clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
   logic [3:0]  rx_queue_length_code [4], tx_queue_length_code [4];
   logic [3:0]  config_queue_length_code, peripheral_queue_length_code;
   logic [9:0]  rx_queue_len_dw [4], tx_queue_len_dw [4], config_queue_len_dw, peripheral_queue_len_dw;
   int          error_cnt = 0, check_count = 0;
   always #50 clk = ~clk;
   iql_regs iql_regs_i (.*);
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr_reg
   // data is looked at mid-cycle, the only cycle it stands
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask : rd_chk
   task t_reset;
      rd_chk(8'h0C, 32'h00000000);
      rd_chk(8'h10, 32'h00000000);
      chk(rx_queue_len_dw[0], 32'h20);
   endtask : t_reset
   // lengths are doubleword counts upward from a base that software keeps aligned
   task t_chan;
      wr_reg(8'h0C, 32'h0F1E2D3C);
      rd_chk(8'h0C, 32'h0F1E2D3C);
      chk(tx_queue_length_code[1], 32'hD);
      chk({rx_queue_length_code[0], rx_queue_length_code[1], rx_queue_length_code[2],
           rx_queue_length_code[3], tx_queue_length_code[0], tx_queue_length_code[1],
           tx_queue_length_code[2], tx_queue_length_code[3]}, 32'h0F1E2D3C);
      chk(rx_queue_len_dw[2], 32'h40);
      chk(rx_queue_len_dw[3], 32'h1E0);
      chk(tx_queue_len_dw[0], 32'h60);
      chk(tx_queue_len_dw[1], 32'h1C0);
      chk(tx_queue_len_dw[2], 32'h80);
      chk(rx_queue_len_dw[1], 32'h200);
      chk(rx_queue_len_dw[0], 32'h20);
      chk(tx_queue_len_dw[3], 32'h1A0);
   endtask : t_chan
   task t_shared;
      wr_reg(8'h10, 32'hFFFFFFFF);
      rd_chk(8'h10, 32'h00FF0000);
      chk(config_queue_len_dw, 32'h200);
      wr_reg(8'h10, 32'h00A50000);
      rd_chk(8'h10, 32'h00A50000);
      chk(config_queue_len_dw, 32'h160);
      chk(peripheral_queue_len_dw, 32'hC0);
      chk({config_queue_length_code, peripheral_queue_length_code}, 32'hA5);
   endtask : t_shared
   // a write while the clock enable is low must leave the register untouched
   task t_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      wr_reg(8'h0C, 32'h11111111);
      chk(tx_queue_length_code[1], 32'hD);
      clk_en <= 1'b1;
      rd_chk(8'h0C, 32'h0F1E2D3C);
   endtask : t_freeze
   task t_unmapped;
      wr_reg(8'h14, 32'hFFFFFFFF);
      rd_chk(8'h14, 32'h00000000);
      rd_chk(8'h0C, 32'h0F1E2D3C);
   endtask : t_unmapped
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_chan;
      t_shared;
      t_unmapped;
      t_freeze;
      report_and_stop;
   end
endmodule : iql_regs_test
bind iql_regs iql_regs_checker iql_regs_checker_i (.*);
